/* File: src/poe_ctrl_pkg.sv */
// Purpose: Shared constants for the power controller control plane
// Assumes: Core clock mclk at 10 MHz
// Notes:   Figures are kept in their own unit; cycle counts derive from them
package poe_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned INT_OSC_KHZ_X1K = 47_972_000;  // Nominal on-chip oscillator, Hz

  // ----------------------------------------------------------------
  // Link rates
  // ----------------------------------------------------------------
  localparam int unsigned MGR_BIT_HZ   = 1_000_000;
  localparam int unsigned MGR_HALF_CYC = CLK_HZ / (2 * MGR_BIT_HZ);
  localparam int unsigned UART_BAUD    = 19_200;
  localparam int unsigned UART_DIV_CYC = CLK_HZ / UART_BAUD;
  localparam int unsigned I2C_MAX_HZ   = 400_000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PG_HOLDUP_NS  = 5_000;
  localparam int unsigned PG_HOLDUP_CYC = PG_HOLDUP_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned DEB_CYC       = 8;
  localparam int unsigned INIT_CYC      = 64;
  localparam int unsigned WD_PULL_CYC   = 8;

  // ----------------------------------------------------------------
  // Frames and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_W     = 48;
  localparam int unsigned LED_PORTS   = 48;
  localparam int unsigned CMD_W       = 8;
  localparam logic [7:0]  CMD_RESET   = 8'h5A;
  localparam logic [7:0]  CMD_DISABLE = 8'hD1;
  localparam int unsigned SENSE_W     = 6;
  localparam logic [5:0]  SENSE_RST   = 6'h01;
  localparam int unsigned BANK_W      = 16;
  localparam int unsigned NUM_BANKS   = 16;

  typedef enum logic [5:0] {
    ST_HOLD     = 6'h01,
    ST_INIT     = 6'h02,
    ST_SEND_RST = 6'h04,
    ST_RUN      = 6'h08,
    ST_SEND_DIS = 6'h10,
    ST_LED      = 6'h20
  } ctrl_state_t;

endpackage

/* File: src/mgr_serial_tx.sv */
// Purpose: Shared serial shifter for the manager bus and the LED chain
// Assumes: miso_sync already passed two flip-flops
// Notes:   Data changes on falling clock, sampled on rising; MSB first
`timescale 1ns/100ps
module mgr_serial_tx
  import poe_ctrl_pkg::*;
#(
  parameter int WIDTH = 48
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Request
  input  wire logic             start,
  input  wire logic             abort,
  input  wire logic             to_led,
  input  wire logic [5:0]       nbits,
  input  wire logic [WIDTH-1:0] data,
  output logic                  done,
  output logic [7:0]            rx_data,
  // Pins
  input  wire logic             miso_sync,
  output logic                  sclk,
  output logic                  mosi,
  output logic                  mgr_cs_n,
  output logic                  led_select_n
);
  localparam logic [7:0] HALF_LAST = 8'(MGR_HALF_CYC - 1);

  logic             busy_reg;
  logic [7:0]       div_reg;
  logic [5:0]       left_reg;
  logic [WIDTH-1:0] shift_reg;
  wire              half_end = busy_reg && (div_reg == HALF_LAST);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_reg     <= 1'b0;
      div_reg      <= 8'h00;
      left_reg     <= 6'h00;
      shift_reg    <= '0;
      sclk         <= 1'b0;
      mosi         <= 1'b0;
      mgr_cs_n     <= 1'b1;
      led_select_n <= 1'b1;
      done         <= 1'b0;
      rx_data      <= 8'h00;
    end else begin
      done    <= 1'b0;
      div_reg <= half_end || !busy_reg ? 8'h00 : div_reg + 8'h01;
      if (abort) begin
        // Reset pin low: drop the frame in flight so INIT finds the shifter idle
        busy_reg     <= 1'b0;
        sclk         <= 1'b0;
        mgr_cs_n     <= 1'b1;
        led_select_n <= 1'b1;
      end else if (!busy_reg && start) begin
        busy_reg     <= 1'b1;
        shift_reg    <= data;
        left_reg     <= nbits;
        sclk         <= 1'b0;
        mosi         <= data[WIDTH-1];
        mgr_cs_n     <= to_led;
        led_select_n <= !to_led;
      end else if (half_end && !sclk) begin
        sclk    <= 1'b1;
        rx_data <= {rx_data[6:0], miso_sync};
      end else if (half_end) begin
        sclk <= 1'b0;
        if (left_reg == 6'h01) begin
          busy_reg     <= 1'b0;
          mgr_cs_n     <= 1'b1;
          led_select_n <= 1'b1;
          done         <= 1'b1;
        end else begin
          left_reg  <= left_reg - 6'h01;
          shift_reg <= shift_reg << 1;
          mosi      <= shift_reg[WIDTH-2];
        end
      end
    end
  end

  a_bit_rate: assert property (@(posedge mclk) disable iff (!nrst || abort)
    $rose(sclk) |-> ##5 $fell(sclk))
    else $error("manager clock high time is not half a 1 MHz bit");
  a_one_select: assert property (@(posedge mclk) disable iff (!nrst)
    !(!mgr_cs_n && !led_select_n))
    else $error("manager select and LED select both active");

endmodule // mgr_serial_tx

/* File: src/poe_ctrl_top.sv */
// Purpose: Control plane of the power-over-Ethernet system controller
// Assumes: mclk 10 MHz; only the off, reset, supply-good, SCL and MISO pins are asynchronous
// Notes:   One output enable covers every push-pull pin; reset and SCL lines are open drain with their own enables
`timescale 1ns/100ps
module poe_ctrl_top
  import poe_ctrl_pkg::*;
#(
  parameter int WD_TIMEOUT_CYC = 100_000,
  parameter int LED_PERIOD_CYC = 10_000
) (
  // Clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  nrst,
  // Host control lines
  input  wire logic                                  all_ports_off_n,
  input  wire logic                                  system_reset_in_n,
  output logic                                       reset_pull_oe,
  // Host interface selection and timing
  input  wire logic [3:0]                            addr_sense_code,
  output logic                                       host_uart_sel,
  output logic [6:0]                                 i2c_target_addr,
  output logic                                       uart_baud_tick,
  input  wire logic                                  i2c_scl_in,
  input  wire logic                                  host_link_busy,
  output logic                                       i2c_scl_oe,
  // Events and watchdog
  input  wire logic                                  sys_event,
  input  wire logic                                  irq_ack,
  input  wire logic                                  wd_kick,
  output logic                                       event_irq_n,
  // Manager bus and LED chain
  input  wire logic                                  mgr_miso,
  output logic                                       mgr_sclk,
  output logic                                       mgr_mosi,
  output logic                                       mgr_cs_n,
  output logic [7:0]                                 mgr_rx_data,
  input  wire logic [poe_ctrl_pkg::LED_PORTS-1:0]    led_status,
  output logic                                       led_select_n,
  output logic                                       led_output_enable,
  output logic                                       led_latch_strobe,
  output logic                                       pin_oe,
  // Power banks
  input  wire logic [3:0]                            supply_good,
  input  wire logic                                  bank_wr_en,
  input  wire logic [3:0]                            bank_wr_idx,
  input  wire logic [poe_ctrl_pkg::BANK_W-1:0]       bank_wr_data,
  output logic [poe_ctrl_pkg::BANK_W-1:0]            power_budget
);
  import poe_ctrl_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Input synchronisers and debounce
  // ----------------------------------------------------------------
  wire  [SENSE_W-1:0] raw = {supply_good, system_reset_in_n, all_ports_off_n};
  logic [SENSE_W-1:0] s1_reg, s2_reg, deb_reg, deb_prev_reg;
  logic [3:0]         deb_cnt_reg [SENSE_W];

  genvar gi;
  generate
    for (gi = 0; gi < SENSE_W; gi++) begin : g_deb
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          s1_reg[gi]      <= SENSE_RST[gi];
          s2_reg[gi]      <= SENSE_RST[gi];
          deb_reg[gi]     <= SENSE_RST[gi];
          deb_cnt_reg[gi] <= 4'h0;
        end else begin
          s1_reg[gi] <= raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          if (s2_reg[gi] == deb_reg[gi]) begin
            deb_cnt_reg[gi] <= 4'h0;
          end else if (deb_cnt_reg[gi] == 4'(DEB_CYC - 1)) begin
            deb_reg[gi]     <= s2_reg[gi];
            deb_cnt_reg[gi] <= 4'h0;
          end else begin
            deb_cnt_reg[gi] <= deb_cnt_reg[gi] + 4'h1;
          end
        end
      end
    end
  endgenerate

  wire       off_n_deb  = deb_reg[0];
  wire       rst_n_deb  = deb_reg[1];
  wire [3:0] pg_deb     = deb_reg[5:2];
  wire       off_fall   = deb_prev_reg[0] && !off_n_deb;
  wire       pg_changed = deb_prev_reg[5:2] != pg_deb;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ctrl_state_t             state_reg, state_next;
  logic [15:0]             init_cnt_reg;
  logic [31:0]             led_tmr_reg;
  logic                    dis_pend_reg, start_reg, to_led_reg;
  logic [5:0]              nbits_reg;
  logic [FRAME_W-1:0]      tx_data_reg;
  logic [3:0]              strap_reg;
  logic                    tx_done;

  wire init_end  = (state_reg == ST_INIT) && (init_cnt_reg == 16'(INIT_CYC - 1));
  wire led_due   = led_tmr_reg >= 32'(LED_PERIOD_CYC - 1);
  wire run_dis   = (state_reg == ST_RUN) && dis_pend_reg;
  wire run_led   = (state_reg == ST_RUN) && !dis_pend_reg && led_due;
  wire sent_done = tx_done && (state_reg inside {ST_SEND_RST, ST_SEND_DIS, ST_LED});

  always_comb begin
    state_next = state_reg;
    if (!rst_n_deb)     state_next = ST_HOLD;
    else if (state_reg == ST_HOLD) state_next = ST_INIT;
    else if (init_end)  state_next = ST_SEND_RST;
    else if (run_dis)   state_next = ST_SEND_DIS;
    else if (run_led)   state_next = ST_LED;
    else if (sent_done) state_next = ST_RUN;
  end

  // Strap is caught in INIT, after the pin reset lets go
  function automatic logic [6:0] strap_addr(input logic [3:0] code);
    return {1'b0, code, 2'b00};
  endfunction

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= ST_HOLD;
      deb_prev_reg <= SENSE_RST;
      init_cnt_reg <= 16'h0000;
      strap_reg    <= 4'h0;
      pin_oe       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      deb_prev_reg <= deb_reg;
      init_cnt_reg <= (state_reg == ST_INIT) ? init_cnt_reg + 16'h0001 : 16'h0000;
      if (state_reg == ST_INIT) strap_reg <= addr_sense_code;
      pin_oe       <= (state_next != ST_HOLD);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dis_pend_reg <= 1'b0;
      start_reg    <= 1'b0;
      to_led_reg   <= 1'b0;
      nbits_reg    <= 6'h00;
      tx_data_reg  <= '0;
      led_tmr_reg  <= 32'h0000_0000;
    end else begin
      start_reg    <= init_end || run_dis || run_led;
      dis_pend_reg <= off_fall || (dis_pend_reg && !run_dis);
      led_tmr_reg  <= run_led ? 32'h0000_0000 : led_tmr_reg + {31'h0, !led_due};
      if (init_end || run_dis) begin
        to_led_reg  <= 1'b0;
        nbits_reg   <= 6'(CMD_W);
        tx_data_reg <= {init_end ? CMD_RESET : CMD_DISABLE, (FRAME_W - CMD_W)'(0)};
      end else if (run_led) begin
        to_led_reg  <= 1'b1;
        nbits_reg   <= 6'(LED_PORTS);
        tx_data_reg <= led_status;
      end
    end
  end

  // ----------------------------------------------------------------
  // Manager bus / LED shifter
  // ----------------------------------------------------------------
  logic miso_s1_reg, miso_s2_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      miso_s1_reg <= mgr_miso;
      miso_s2_reg <= miso_s1_reg;
    end
  end

  // A frame cut by the reset pin must not swallow the reset command after INIT
  wire tx_abort = (state_reg == ST_HOLD);

  mgr_serial_tx #(.WIDTH(FRAME_W)) u_tx (
    .mclk         (mclk),
    .nrst         (nrst),
    .abort        (tx_abort),
    .start        (start_reg),
    .to_led       (to_led_reg),
    .nbits        (nbits_reg),
    .data         (tx_data_reg),
    .done         (tx_done),
    .rx_data      (mgr_rx_data),
    .miso_sync    (miso_s2_reg),
    .sclk         (mgr_sclk),
    .mosi         (mgr_mosi),
    .mgr_cs_n     (mgr_cs_n),
    .led_select_n (led_select_n)
  );

  // ----------------------------------------------------------------
  // Host side, watchdog, events, power banks
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] bank_mem [NUM_BANKS];
  logic [9:0]        uart_div_reg;
  logic              scl_s1_reg, scl_s2_reg, scl_prev_reg;
  logic [31:0]       wd_cnt_reg;
  logic [3:0]        wd_pull_reg;
  logic              irq_flag_reg;

  wire running   = state_reg != ST_HOLD;
  wire uart_wrap = uart_div_reg == 10'(UART_DIV_CYC - 1);
  wire scl_fall  = scl_prev_reg && !scl_s2_reg;
  wire wd_fire   = running && (wd_cnt_reg == 32'(WD_TIMEOUT_CYC - 1));
  wire irq_next  = sys_event || pg_changed || (irq_flag_reg && !irq_ack);

  always_ff @(posedge mclk) begin
    if (bank_wr_en) bank_mem[bank_wr_idx] <= bank_wr_data;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      host_uart_sel     <= 1'b1;
      i2c_target_addr   <= 7'h00;
      uart_div_reg      <= 10'h000;
      uart_baud_tick    <= 1'b0;
      scl_s1_reg        <= 1'b1;
      scl_s2_reg        <= 1'b1;
      scl_prev_reg      <= 1'b1;
      i2c_scl_oe        <= 1'b0;
      wd_cnt_reg        <= 32'h0000_0000;
      wd_pull_reg       <= 4'h0;
      reset_pull_oe     <= 1'b0;
      irq_flag_reg      <= 1'b0;
      event_irq_n       <= 1'b1;
      power_budget      <= '0;
      led_latch_strobe  <= 1'b0;
      led_output_enable <= 1'b0;
    end else begin
      host_uart_sel   <= (strap_reg == 4'h0);
      i2c_target_addr <= strap_addr(strap_reg);
      uart_div_reg    <= uart_wrap || !host_uart_sel ? 10'h000 : uart_div_reg + 10'h001;
      uart_baud_tick  <= uart_wrap && host_uart_sel && running;
      scl_s1_reg      <= i2c_scl_in;
      scl_s2_reg      <= scl_s1_reg;
      scl_prev_reg    <= scl_s2_reg;
      // Stretch low after a falling edge while the core is busy
      i2c_scl_oe      <= !host_uart_sel && running && host_link_busy
                         && (scl_fall || i2c_scl_oe);
      wd_cnt_reg      <= (wd_kick || !running || wd_fire) ? 32'h0 : wd_cnt_reg + 32'h1;
      wd_pull_reg     <= wd_fire ? 4'(WD_PULL_CYC) : wd_pull_reg - {3'h0, |wd_pull_reg};
      reset_pull_oe   <= wd_fire || (wd_pull_reg > 4'h1);
      irq_flag_reg    <= irq_next;
      event_irq_n     <= !irq_next;
      power_budget    <= bank_mem[pg_deb];
      led_latch_strobe  <= tx_done && (state_reg == ST_LED);
      led_output_enable <= led_output_enable || (tx_done && (state_reg == ST_LED));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence pg_settled;
    $changed(s2_reg[5:2]) ##1 $stable(s2_reg[5:2]) [*8];
  endsequence
  sequence disable_frame;
    start_reg && !to_led_reg && (tx_data_reg[FRAME_W-1 -: CMD_W] == CMD_DISABLE);
  endsequence

  a_hold_tristate: assert property (!rst_n_deb |=> !pin_oe)
    else $error("pins driven while reset pin low");
  a_reset_cmd: assert property ($rose(state_reg == ST_SEND_RST) |-> start_reg
    && (tx_data_reg[FRAME_W-1 -: CMD_W] == CMD_RESET))
    else $error("reset command not issued after init");
  a_disable_cmd: assert property ($fell(off_n_deb)
    && rst_n_deb |-> ##[1:600] disable_frame)
    else $error("disable command not sent");
  a_wd_pull: assert property (wd_fire |=> reset_pull_oe [*8] ##1 !reset_pull_oe)
    else $error("watchdog pull not eight cycles");
  a_addr_decode: assert property (state_reg == ST_RUN && $past(state_reg) == ST_RUN
    |-> host_uart_sel == (strap_reg == 4'h0) && i2c_target_addr == {1'b0, strap_reg, 2'b00})
    else $error("strap decode mismatch");
  a_pg_budget: assert property (pg_settled |-> ##[1:40]
    (power_budget == bank_mem[s2_reg[5:2]]))
    else $error("budget did not follow power-good within hold-up time");
  a_irq_set: assert property (sys_event |=> !event_irq_n)
    else $error("event did not raise interrupt");
  a_led_latch: assert property (led_latch_strobe |-> $past(state_reg) == ST_LED
    ##1 led_output_enable && !led_latch_strobe)
    else $error("latch strobe outside LED transfer");

endmodule // poe_ctrl_top

/* File: verif/mgr_bus_model.sv */
// Purpose: Behavioural port managers and LED chain on the shared serial lines
// Assumes: Bits change on a falling serial clock and are taken on a rising one
// Notes:   A released reply line shows the inverse of its last value, no pull
`timescale 1ns/100ps
module mgr_bus_model #(
  parameter logic [7:0] RESP = 8'hC6
) (
  // Serial lines
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        mgr_cs_n,
  input  wire logic        led_select_n,
  output logic             miso,
  // Captured traffic
  output logic [47:0]      rx_shift,
  output int               cmd_count,
  output int               led_count,
  output int               bit_errs
);
  int      idx;
  realtime t_rise;
  logic    cs_prev, led_prev, sclk_prev;

  // ----------------------------------------------------------------
  // One process owns every model variable; edges are found against
  // the levels seen at the previous wake-up
  // ----------------------------------------------------------------
  initial begin
    miso      = 1'b0;
    rx_shift  = '0;
    cmd_count = 0;
    led_count = 0;
    bit_errs  = 0;
    idx       = 0;
    t_rise    = 0;
    cs_prev   = 1'b1;
    led_prev  = 1'b1;
    sclk_prev = 1'b0;
    forever begin
      @(mgr_cs_n or led_select_n or sclk);
      // Every manager listens under the one common select
      if ((!mgr_cs_n && cs_prev) || (!led_select_n && led_prev)) begin
        t_rise = 0;
        idx    = 7;
        if (!mgr_cs_n) miso = RESP[7];
      end
      // Bit spacing must be one microsecond inside a frame
      if (sclk && !sclk_prev && (!mgr_cs_n || !led_select_n)) begin
        if (t_rise != 0 && $realtime - t_rise != 1000.0) bit_errs++;
        t_rise   = $realtime;
        rx_shift = {rx_shift[46:0], mosi};
      end
      if (!sclk && sclk_prev && !mgr_cs_n && idx > 0) begin
        idx--;
        miso = RESP[idx];
      end
      if (mgr_cs_n && !cs_prev) begin
        cmd_count++;
        miso = ~miso;
      end
      if (led_select_n && !led_prev) led_count++;
      cs_prev   = mgr_cs_n;
      led_prev  = led_select_n;
      sclk_prev = sclk;
    end
  end
endmodule // mgr_bus_model

/* File: verif/poe_ctrl_top_tb.sv */
// Purpose: Self-checking bench for the controller control plane
// Assumes: Inputs change on the falling clock, except SCL on its own 400 ns toggle; short watchdog and LED periods
// Notes:   Reset and SCL lines are open drain with pull-ups, resolved here
`timescale 1ns/100ps
module poe_ctrl_top_tb;
  import poe_ctrl_pkg::*;
  localparam int          WD   = 200;
  localparam logic [7:0]  RESP = 8'hC6;
  localparam logic [47:0] LEDS = 48'hA5C3_0F96_1E2D;
  logic        mclk, nrst, all_ports_off_n, host_rst_lo, scl_drv, scl_run;
  logic        host_link_busy, sys_event, irq_ack, wd_kick, kick_en, bank_wr_en;
  logic [3:0]  addr_sense_code, supply_good, bank_wr_idx;
  logic [15:0] bank_wr_data, bexp;
  logic [47:0] led_status, rx_shift;
  wire logic   reset_pull_oe, host_uart_sel, uart_baud_tick, i2c_scl_oe, event_irq_n;
  wire logic   mgr_sclk, mgr_mosi, mgr_cs_n, mgr_miso, led_select_n, pin_oe;
  wire logic   led_output_enable, led_latch_strobe, system_reset_in_n, i2c_scl_in;
  wire logic [6:0]  i2c_target_addr;
  wire logic [7:0]  mgr_rx_data;
  wire logic [15:0] power_budget;
  int          cmd_count, led_count, bit_errs, cmd0, led0, n;
  int          fail_count = 0;
  int          cmp_count = 0;

  // ----------------------------------------------------------------
  // Clock, open-drain lines, watchdog kicker
  // ----------------------------------------------------------------
  always #50 mclk = ~mclk;
  assign system_reset_in_n = !(host_rst_lo || reset_pull_oe);
  assign i2c_scl_in = scl_drv && !i2c_scl_oe;
  initial begin
    #13;
    forever #400 if (scl_run && !i2c_scl_oe) scl_drv = ~scl_drv;
  end
  always @(negedge mclk) wd_kick <= kick_en && ($time / 100) % 40 == 0;

  poe_ctrl_top #(.WD_TIMEOUT_CYC(WD), .LED_PERIOD_CYC(600)) dut_u (
    .mclk, .nrst, .all_ports_off_n, .system_reset_in_n, .reset_pull_oe,
    .addr_sense_code, .host_uart_sel, .i2c_target_addr, .uart_baud_tick,
    .i2c_scl_in, .host_link_busy, .i2c_scl_oe, .sys_event, .irq_ack, .wd_kick,
    .event_irq_n, .mgr_miso, .mgr_sclk, .mgr_mosi, .mgr_cs_n, .mgr_rx_data,
    .led_status, .led_select_n, .led_output_enable, .led_latch_strobe, .pin_oe,
    .supply_good, .bank_wr_en, .bank_wr_idx, .bank_wr_data, .power_budget);

  mgr_bus_model #(.RESP(RESP)) model_u (
    .sclk(mgr_sclk), .mosi(mgr_mosi), .mgr_cs_n, .led_select_n, .miso(mgr_miso),
    .rx_shift, .cmd_count, .led_count, .bit_errs);

  // ----------------------------------------------------------------
  // Compare, wait and report tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic bit hit(input int w);
    case (w)
      0: return cmd_count != cmd0;
      1: return led_count != led0;
      2: return reset_pull_oe === 1'b1;
      3: return power_budget === bexp;
      4: return i2c_scl_oe === 1'b1;
      5: return i2c_scl_oe === 1'b0;
      default: return uart_baud_tick === 1'b1;
    endcase
  endfunction

  // Never open-ended: running out of the bound ends the run as a mismatch
  task automatic wait_ev(input int w, input int lim);
    n = 0;
    while (!hit(w)) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        fail_count++;
        $display("ERROR t=%0t wait=%0h limit=%0h", $time, w, lim);
        results();
      end
    end
  endtask

  task automatic pulse_ack();
    irq_ack = 1'b1;
    @(negedge mclk);
    irq_ack = 1'b0;
  endtask

  // Hold the block, then release it and expect the reset command
  task automatic boot(input logic [3:0] c);
    host_rst_lo     = 1'b1;
    addr_sense_code = c;
    repeat (20) @(negedge mclk);
    chk(pin_oe, 0);
    cmd0        = cmd_count;
    host_rst_lo = 1'b0;
    wait_ev(0, 300);
    chk(n > 140, 1);
    chk(rx_shift[7:0], CMD_RESET);
    chk(mgr_rx_data, RESP);
    chk(pin_oe, 1);
    chk(host_uart_sel, c == 4'h0);
    if (c != 4'h0) chk(i2c_target_addr, {1'b0, c, 2'b00});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {mclk, nrst, host_rst_lo, scl_drv, scl_run, host_link_busy} = 6'h04;
    {sys_event, irq_ack, bank_wr_en} = 3'h0;
    {all_ports_off_n, kick_en} = 2'h3;
    {addr_sense_code, supply_good, bank_wr_idx, bank_wr_data} = 28'h0;
    led_status = LEDS;
    repeat (20) @(negedge mclk);
    chk({pin_oe, mgr_cs_n, led_select_n, event_irq_n}, 4'h7);
    nrst = 1'b1;
    for (int c = 15; c >= 0; c--) boot(c[3:0]);
    wait_ev(6, 600);
    @(negedge mclk);
    wait_ev(6, 600);
    chk(n, UART_DIV_CYC - 1);
    // A short dip on the disable pin must be ignored
    cmd0 = cmd_count;
    all_ports_off_n = 1'b0;
    repeat (4) @(negedge mclk);
    all_ports_off_n = 1'b1;
    repeat (100) @(negedge mclk);
    chk(cmd_count, cmd0);
    all_ports_off_n = 1'b0;
    wait_ev(0, 700);
    chk(rx_shift[7:0], CMD_DISABLE);
    all_ports_off_n = 1'b1;
    led0 = led_count;
    wait_ev(1, 700);
    chk(rx_shift, LEDS);
    @(negedge mclk);
    chk(led_latch_strobe, 1);
    @(negedge mclk);
    chk({led_latch_strobe, led_output_enable}, 2'h1);
    pulse_ack();
    chk(event_irq_n, 1);
    sys_event = 1'b1;
    @(negedge mclk);
    sys_event = 1'b0;
    chk(event_irq_n, 0);
    pulse_ack();
    chk(event_irq_n, 1);
    for (int i = 0; i < 16; i++) begin
      bank_wr_en   = 1'b1;
      bank_wr_idx  = i[3:0];
      bank_wr_data = {4'hB, i[3:0], ~i[3:0], i[3:0]};
      @(negedge mclk);
    end
    bank_wr_en = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      supply_good = i[3:0];
      bexp        = {4'hB, i[3:0], ~i[3:0], i[3:0]};
      wait_ev(3, PG_HOLDUP_CYC);
      chk(power_budget, bexp);
      @(negedge mclk);
      chk(event_irq_n, 0);
      pulse_ack();
    end
    boot(4'h6);
    scl_run = 1'b1;
    host_link_busy = 1'b1;
    wait_ev(4, 100);
    repeat (20) @(negedge mclk);
    chk({i2c_scl_in, i2c_scl_oe}, 2'h1);
    host_link_busy = 1'b0;
    wait_ev(5, 100);
    kick_en = 1'b0;
    wait_ev(2, WD + 50);
    chk(n >= WD - 45 && n <= WD + 5, 1);
    n = 0;
    while (reset_pull_oe === 1'b1 && n < 20) begin
      n++;
      @(negedge mclk);
    end
    chk(n, WD_PULL_CYC);
    chk(bit_errs, 0);
    results();
  end
endmodule // poe_ctrl_top_tb
